// *** hw/rsseq_pkg.sv ***
// Constants, register map and state type for the reset sequencer.
// Assumes a single 25 MHz clock and classic Wishbone register access.
// What this block does
// [RQ1] Tell apart power-on, watchdog run/sleep, pin run/sleep and brown-out resets.
// [RQ2] Unaffected bits keep their contents through every reset except power-on.
// [RQ3] Resets load register reset state; watchdog wake-up resumes instead.
// [RQ4] Reset pin low pulses shorter than the filter length are ignored.
// [RQ5] Watchdog reset never drives the reset pin low.
// [RQ6] Internal tie select forces the reset pin inactive; no pull-up exists.
// [RQ7] Power-on detector holds reset at power-up only, not on later dips.
// [RQ8] Power-up timer gives a 72 ms hold after power-on or brown-out only.
// [RQ9] Power-up timer is disabled by a 1 and enabled by a 0.
// [RQ10] Configuring party should enable the power-up timer with brown-out detection.
// [RQ11] Start-up counter counts 1024 oscillator ticks after the power-up delay.
// [RQ12] Start-up count applies only in the three crystal modes.
// [RQ13] Delay totals per mode, timer setting and wake follow the time-out table.
// [RQ14] Brown-out enable 1 arms detection; long enough dips reset the device.
// [RQ15] Reset holds until supply is above threshold, then power-up timer runs.
// [RQ16] Brown-out during the power-up delay restarts it from zero.
// [RQ17] Power-up delay follows power-on pulse; external clock, timer off: none.
// [RQ18] Delays run from power-on regardless of pin; later pin release starts at once.
// [RQ19] Brown-out flag is cleared by brown-out and set by software.
// [RQ20] Power-on flag clears on power-on and is set by software writing 1.
// [RQ21] Timeout and power-down flags encode the reset cause as tabled.
// [RQ22] Status loads 0001 1xxx on power-on or brown-out, 000q quuu otherwise.
// [RQ23] Non-wake resets restart the program counter; wake continues.
// [RQ24] Internal reset releases only when every hold source is clear.
package rsseq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  CORE_STATUS_IDX    = 10'h003;
  localparam logic [9:0]  POWER_FLAGS_IDX    = 10'h08e;
  localparam int          ADDR_W             = 12;

  // Field positions
  localparam int          TIMEOUT_BIT        = 4;
  localparam int          POWERDOWN_BIT      = 3;
  localparam int          POR_FLAG_BIT       = 1;
  localparam int          BROWNOUT_FLAG_BIT  = 0;

  // Values after reset
  localparam logic [7:0]  STATUS_RST         = 8'h18;
  localparam logic [1:0]  POWER_FLAGS_RST    = 2'h0;

  // Oscillator mode codes
  localparam logic [2:0]  LOW_POWER_CRYSTAL_MODE    = 3'h0;
  localparam logic [2:0]  STANDARD_CRYSTAL_MODE     = 3'h1;
  localparam logic [2:0]  HIGH_SPEED_CRYSTAL_MODE   = 3'h2;
  localparam logic [2:0]  EXTERNAL_CLOCK_INPUT_MODE = 3'h3;
  localparam logic [2:0]  INTERNAL_OSC_MODE         = 3'h4;

  // Timing
  localparam longint      CLK_HZ             = 25000000;
  localparam longint      PUP_DELAY_MS       = 72;
  localparam int          PUP_DELAY_CYCLES   = int'((PUP_DELAY_MS * CLK_HZ) / 1000);
  localparam int          XTAL_WAIT_TICKS    = 1024;
  localparam int          PIN_FILTER_CYCLES  = 3;
  localparam int          DIP_MIN_CYCLES     = 4;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_PUP,
    SEQ_XTAL,
    SEQ_RUN
  } rsseq_state_type;

endpackage : rsseq_pkg

// *** hw/rsseq_top.sv ***
// Reset source merger and start-up sequencer with its cause flags.
// Assumes detector, pin and oscillator tick inputs synchronous to CLK.
`timescale 1ns/1ps
module rsseq_top #(
  parameter int PUP_CYCLES  = rsseq_pkg::PUP_DELAY_CYCLES,
  parameter int XTAL_TICKS  = rsseq_pkg::XTAL_WAIT_TICKS,
  parameter int PIN_FILTER  = rsseq_pkg::PIN_FILTER_CYCLES,
  parameter int DIP_MIN     = rsseq_pkg::DIP_MIN_CYCLES
) (
  input  wire logic                        CLK,
  input  wire logic                        RESET,
  input  wire logic                        POWER_ON_DET,
  input  wire logic                        BROWNOUT_DET,
  input  wire logic                        EXTERNAL_RESET_PIN_N,
  input  wire logic                        WATCHDOG_TIMEOUT,
  input  wire logic                        SLEEP_ACTIVE,
  input  wire logic                        OSC_TICK,
  input  wire logic                        POWERUP_TIMER_DISABLE,
  input  wire logic                        BROWNOUT_ENABLE,
  input  wire logic                        INTERNAL_RESET_TIE_SEL,
  input  wire logic [2:0]                  OSC_MODE,
  input  wire logic                        WB_CYC_I,
  input  wire logic                        WB_STB_I,
  input  wire logic                        WB_WE_I,
  input  wire logic [rsseq_pkg::ADDR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]                  WB_SEL_I,
  input  wire logic [31:0]                 WB_DAT_I,
  output logic      [31:0]                 WB_DAT_O,
  output logic                             WB_ACK_O,
  output logic                             CORE_RESET,
  output logic                             REG_RESET_LOAD,
  output logic                             PC_RESTART,
  output logic                             WAKE_RESUME,
  output logic                             RESET_PIN_OE
);

  // Start-up counts must hold at least two steps, filter counts at least one
  if (PUP_CYCLES < 2 || XTAL_TICKS < 2 || PIN_FILTER < 1 || DIP_MIN < 1 ||
      PIN_FILTER > 65535 || DIP_MIN > 65535) begin : g_chk
    $error("rsseq_top: counts out of range");
  end

  rsseq_pkg::rsseq_state_type state_r;
  logic [31:0] pup_cnt_r;
  logic [31:0] xtal_cnt_r;
  logic [15:0] pin_cnt_r;
  logic [15:0] dip_cnt_r;
  logic        pin_low_r;
  logic        dip_low_r;
  logic        por_done_r;
  logic        wake_r;
  logic        wdog_rst_r;
  logic [7:0]  status_r;
  logic [1:0]  power_flags_r;
  logic        core_reset_nxt;
  logic        por_act;
  logic        dip_act;
  logic        pin_raw;
  logic        xtal_mode;
  logic        pin_fall;
  logic        wdog_run;
  logic        wdog_wake;
  logic        wb_req;
  logic        wr_status;
  logic        wr_flags;

  // Mode test used by both the start-up choice and the wake path
  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == rsseq_pkg::LOW_POWER_CRYSTAL_MODE) ||
                 (mode == rsseq_pkg::STANDARD_CRYSTAL_MODE) ||
                 (mode == rsseq_pkg::HIGH_SPEED_CRYSTAL_MODE);
  endfunction : is_crystal

  assign xtal_mode = is_crystal(OSC_MODE);             // RQ12
  // Detector is honoured only until it first releases
  assign por_act   = POWER_ON_DET & ~por_done_r;       // RQ7
  assign dip_act   = BROWNOUT_ENABLE & dip_low_r;      // RQ14
  // Tie select ignores the pin entirely
  assign pin_raw   = ~INTERNAL_RESET_TIE_SEL & ~EXTERNAL_RESET_PIN_N; // RQ6
  assign pin_fall  = pin_raw & ~pin_low_r &
                     (pin_cnt_r == 16'(PIN_FILTER - 1));
  assign wdog_run  = WATCHDOG_TIMEOUT & ~SLEEP_ACTIVE & (state_r == rsseq_pkg::SEQ_RUN);
  assign wdog_wake = WATCHDOG_TIMEOUT & SLEEP_ACTIVE & (state_r == rsseq_pkg::SEQ_RUN);

  // Power-on detector is latched off after its first release
  always_ff @(posedge CLK) begin
    if (RESET) begin
      por_done_r <= 1'b0;
    end else if (!POWER_ON_DET) begin
      por_done_r <= 1'b1;                              // RQ7
    end
  end

  // Pin filter: low must persist, high releases at once
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_cnt_r <= 16'h0000;
      pin_low_r <= 1'b0;
    end else if (!pin_raw) begin
      pin_cnt_r <= 16'h0000;
      pin_low_r <= 1'b0;
    end else if (pin_fall) begin
      pin_low_r <= 1'b1;                               // RQ4
    end else if (!pin_low_r) begin
      pin_cnt_r <= pin_cnt_r + 16'h0001;
    end
  end

  // Brown-out needs a minimum dip length before it counts
  always_ff @(posedge CLK) begin
    if (RESET) begin
      dip_cnt_r <= 16'h0000;
      dip_low_r <= 1'b0;
    end else if (!BROWNOUT_DET) begin
      dip_cnt_r <= 16'h0000;
      dip_low_r <= 1'b0;
    end else if (dip_cnt_r == 16'(DIP_MIN - 1)) begin
      dip_low_r <= 1'b1;                               // RQ14
    end else begin
      dip_cnt_r <= dip_cnt_r + 16'h0001;
    end
  end

  // Start-up sequencer; counts every CLK cycle as the timer's own tick
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r    <= rsseq_pkg::SEQ_HOLD;
      pup_cnt_r  <= 32'h0000_0000;
      xtal_cnt_r <= 32'h0000_0000;
      wake_r     <= 1'b0;
    end else begin
      case (state_r)
        rsseq_pkg::SEQ_HOLD: begin
          pup_cnt_r  <= 32'h0000_0000;
          xtal_cnt_r <= 32'h0000_0000;
          wake_r     <= 1'b0;
          // Supply must be good before any delay starts
          if (!por_act && !dip_act) begin              // RQ15
            if (!POWERUP_TIMER_DISABLE) begin          // RQ9
              state_r <= rsseq_pkg::SEQ_PUP;           // RQ17
            end else if (xtal_mode) begin
              state_r <= rsseq_pkg::SEQ_XTAL;          // RQ13
            end else begin
              state_r <= rsseq_pkg::SEQ_RUN;           // RQ17
            end
          end
        end
        rsseq_pkg::SEQ_PUP: begin
          if (por_act || dip_act) begin
            state_r <= rsseq_pkg::SEQ_HOLD;            // RQ16
          end else if (pup_cnt_r == 32'(PUP_CYCLES - 1)) begin
            state_r <= xtal_mode ? rsseq_pkg::SEQ_XTAL : rsseq_pkg::SEQ_RUN; // RQ8
          end else begin
            pup_cnt_r <= pup_cnt_r + 32'h0000_0001;    // RQ8
          end
        end
        rsseq_pkg::SEQ_XTAL: begin
          if (por_act || dip_act) begin
            state_r <= rsseq_pkg::SEQ_HOLD;
          end else if (OSC_TICK) begin
            if (xtal_cnt_r == 32'(XTAL_TICKS - 1)) begin
              state_r <= rsseq_pkg::SEQ_RUN;           // RQ11
            end else begin
              xtal_cnt_r <= xtal_cnt_r + 32'h0000_0001; // RQ11
            end
          end
        end
        default: begin
          xtal_cnt_r <= 32'h0000_0000;
          wake_r     <= 1'b0;
          if (por_act || dip_act) begin
            state_r <= rsseq_pkg::SEQ_HOLD;            // RQ14
          end else if (wdog_wake && xtal_mode) begin
            // Wake waits for the crystal but is no reset
            state_r <= rsseq_pkg::SEQ_XTAL;            // RQ13
            wake_r  <= 1'b1;
          end
        end
      endcase
    end
  end

  // Watchdog reset is an internal pulse only, as long as the timeout input
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wdog_rst_r <= 1'b0;
    end else begin
      wdog_rst_r <= wdog_run;                          // RQ5
    end
  end

  // Reset pin is input only; nothing here ever drives it
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RESET_PIN_OE <= 1'b0;
    end else begin
      RESET_PIN_OE <= 1'b0;                            // RQ5
    end
  end

  // Merge every hold source; the pin never restarts the timers
  always_comb begin
    core_reset_nxt = 1'b0;
    if (state_r == rsseq_pkg::SEQ_HOLD || state_r == rsseq_pkg::SEQ_PUP) begin
      core_reset_nxt = 1'b1;                           // RQ24
    end else if (state_r == rsseq_pkg::SEQ_XTAL && !wake_r) begin
      core_reset_nxt = 1'b1;                           // RQ24
    end else if (pin_low_r || wdog_rst_r) begin
      core_reset_nxt = 1'b1;                           // RQ18
    end
  end

  // Reset output and its edge pulses
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CORE_RESET     <= 1'b1;
      REG_RESET_LOAD <= 1'b1;
      PC_RESTART     <= 1'b0;
      WAKE_RESUME    <= 1'b0;
    end else begin
      CORE_RESET     <= core_reset_nxt;
      // Loaded on reset entry; a watchdog wake never loads it
      REG_RESET_LOAD <= core_reset_nxt & ~CORE_RESET;  // RQ3
      PC_RESTART     <= ~core_reset_nxt & CORE_RESET;  // RQ23
      WAKE_RESUME    <= (wdog_wake & ~xtal_mode) |
                        (wake_r & (state_r == rsseq_pkg::SEQ_XTAL) &
                         OSC_TICK & (xtal_cnt_r == 32'(XTAL_TICKS - 1))); // RQ23
    end
  end

  assign wb_req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_status = wb_req & WB_WE_I & WB_SEL_I[0] &
                     (WB_ADR_I[11:2] == rsseq_pkg::CORE_STATUS_IDX);
  assign wr_flags  = wb_req & WB_WE_I & WB_SEL_I[0] &
                     (WB_ADR_I[11:2] == rsseq_pkg::POWER_FLAGS_IDX);

  // Status register: software owns all but the two cause flags.
  // Hardware events are applied last so they beat a same-cycle write.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      status_r <= rsseq_pkg::STATUS_RST;               // RQ22
    end else begin
      if (wr_status) begin
        status_r[7:5] <= WB_DAT_I[7:5];
        status_r[2:0] <= WB_DAT_I[2:0];
      end
      if (por_act || dip_act) begin                    // RQ2
        // Low bits kept: no detector event touches them; only the RESET input or a software write clears them
        status_r[7:3] <= 5'h03;                        // RQ22
      end else if (wdog_run) begin
        status_r[7:5] <= 3'h0;                         // RQ22
        status_r[rsseq_pkg::TIMEOUT_BIT] <= 1'b0;      // RQ21
      end else if (wdog_wake) begin
        status_r[rsseq_pkg::TIMEOUT_BIT]   <= 1'b0;    // RQ21
        status_r[rsseq_pkg::POWERDOWN_BIT] <= 1'b0;    // RQ21
      end else if (pin_fall && SLEEP_ACTIVE) begin
        status_r[7:5] <= 3'h0;                         // RQ22
        status_r[rsseq_pkg::TIMEOUT_BIT]   <= 1'b1;    // RQ21
        status_r[rsseq_pkg::POWERDOWN_BIT] <= 1'b0;    // RQ21
      end else if (pin_fall) begin
        status_r[7:5] <= 3'h0;                         // RQ1
      end
    end
  end

  // Power flags: cleared by their events, set by software
  always_ff @(posedge CLK) begin
    if (RESET) begin
      power_flags_r <= rsseq_pkg::POWER_FLAGS_RST;     // RQ20
    end else begin
      if (wr_flags) begin
        power_flags_r <= WB_DAT_I[1:0];                // RQ19
      end
      if (por_act) begin
        power_flags_r[rsseq_pkg::POR_FLAG_BIT] <= 1'b0; // RQ20
      end else if (dip_act) begin
        power_flags_r[rsseq_pkg::BROWNOUT_FLAG_BIT] <= 1'b0; // RQ19
      end
    end
  end

  // Wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge CLK) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (WB_ADR_I[11:2] == rsseq_pkg::CORE_STATUS_IDX) begin
        WB_DAT_O[7:0] <= status_r;
      end else if (WB_ADR_I[11:2] == rsseq_pkg::POWER_FLAGS_IDX) begin
        WB_DAT_O[1:0] <= power_flags_r;
      end
    end
  end

endmodule : rsseq_top

// *** bench/rsseq_assertions.sv ***
// Checker for the reset sequencer: bus handshake and reset output timing.
// Assumes it is bound to rsseq_top and sees only that module's ports.
`timescale 1ns/1ps
module rsseq_assertions (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic BROWNOUT_DET,
  input wire logic INTERNAL_RESET_TIE_SEL,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic CORE_RESET,
  input wire logic REG_RESET_LOAD,
  input wire logic PC_RESTART,
  input wire logic WAKE_RESUME,
  input wire logic RESET_PIN_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // The pin is never driven, so a watchdog reset cannot leak onto the board
  chk_pin_oe_off: assert property (RESET_PIN_OE == 1'b0)
    else $error("reset pin output enable raised");
  // Bus answers exactly one cycle after a request is taken, for one cycle
  chk_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  // Entering reset loads register reset state; leaving it restarts the core
  chk_load_on_entry: assert property ($rose(CORE_RESET) |-> ##[0:1] REG_RESET_LOAD)
    else $error("reset entered without register load");
  chk_pc_restart: assert property ($fell(CORE_RESET) |-> ##[0:1] PC_RESTART)
    else $error("reset left without program restart");
  // A wake resumes; it must not look like a reset
  chk_wake_quiet: assert property (WAKE_RESUME |-> !CORE_RESET && !PC_RESTART)
    else $error("wake resume together with reset");
  // With the pin tied inactive and no other source, running stays running
  chk_tie_blocks: assert property (!CORE_RESET && INTERNAL_RESET_TIE_SEL
    && !WATCHDOG_TIMEOUT && !$past(WATCHDOG_TIMEOUT) && !$past(WATCHDOG_TIMEOUT, 2)
    && !BROWNOUT_DET && !$past(BROWNOUT_DET) |=> !CORE_RESET)
    else $error("reset while pin tied inactive");
  // A two-cycle low glitch is below the filter length and is ignored
  chk_pin_glitch: assert property ((!CORE_RESET && EXTERNAL_RESET_PIN_N)
    ##1 !EXTERNAL_RESET_PIN_N [*2] ##1 EXTERNAL_RESET_PIN_N |=> !CORE_RESET [*3])
    else $error("short pin pulse caused reset");
endmodule : rsseq_assertions

bind rsseq_top rsseq_assertions i_chk (.CLK(CLK), .RESET(RESET),
  .EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
  .BROWNOUT_DET(BROWNOUT_DET), .INTERNAL_RESET_TIE_SEL(INTERNAL_RESET_TIE_SEL),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .CORE_RESET(CORE_RESET),
  .REG_RESET_LOAD(REG_RESET_LOAD), .PC_RESTART(PC_RESTART), .WAKE_RESUME(WAKE_RESUME),
  .RESET_PIN_OE(RESET_PIN_OE));

// *** bench/rsseq_top_bench.sv ***
// Self-checking bench for the reset sequencer: start-up delay per mode,
// cause flags and register access over Wishbone.
// Assumes a 20-cycle power-up delay, 8 start-up ticks and a tick every 4 cycles.
`timescale 1ns/1ps
module rsseq_top_bench;
  typedef struct {logic [2:0] mode; logic pdis; int dly;} rsseq_row_type;
  logic          clk, rst, pon, bdet, pin_n, wdog, slp, tick, pdis, ben, tie;
  logic          cyc, stb, we, ack, cr, load, pcr, wake, oe, hit, hw, hl, hp;
  logic [2:0]    mode;
  logic [1:0]    tcnt;
  logic [11:0]   adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat, q;
  int            mismatches, check_count, n;
  // Expected delay: 20 for the timer plus 8 ticks of 4 cycles in crystal modes
  rsseq_row_type rows [7] = '{'{3'h0, 1'b0, 52}, '{3'h1, 1'b1, 32}, '{3'h2, 1'b0, 52},
    '{3'h3, 1'b0, 20}, '{3'h3, 1'b1, 0}, '{3'h4, 1'b0, 20}, '{3'h5, 1'b1, 0}};

  rsseq_top #(.PUP_CYCLES(20), .XTAL_TICKS(8)) i_dut (.CLK(clk), .RESET(rst),
    .POWER_ON_DET(pon), .BROWNOUT_DET(bdet), .EXTERNAL_RESET_PIN_N(pin_n),
    .WATCHDOG_TIMEOUT(wdog), .SLEEP_ACTIVE(slp), .OSC_TICK(tick),
    .POWERUP_TIMER_DISABLE(pdis), .BROWNOUT_ENABLE(ben), .INTERNAL_RESET_TIE_SEL(tie),
    .OSC_MODE(mode), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CORE_RESET(cr),
    .REG_RESET_LOAD(load), .PC_RESTART(pcr), .WAKE_RESUME(wake), .RESET_PIN_OE(oe));

  // Clock and a slow oscillator tick, one pulse every four cycles
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Tick phase restarts with every reset so start-up counts are repeatable
  always @(posedge clk) begin
    if (rst) begin
      tcnt <= 2'h0;
      tick <= 1'b0;
    end else begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One classic cycle; request held until the edge that samples ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) mismatches++;
  endtask : wb

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask : rdc

  // Cycles until the core leaves reset, bounded
  task automatic lowt();
    n = 0;
    while (cr !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask : lowt

  // Sticky record of reset and wake outputs over a span; short pulses are not missed
  task automatic watch(input int k);
    hit = 1'b0;
    hw = 1'b0;
    hl = 1'b0;
    hp = 1'b0;
    repeat (k) begin
      @(posedge clk);
      hit = hit | (cr !== 1'b0);
      hw = hw | (wake === 1'b1);
      hl = hl | (load === 1'b1);
      hp = hp | (pcr === 1'b1);
    end
  endtask : watch

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin : watchdog_limit
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {rst, pon, ben, mode} = 6'h38;
    {bdet, pin_n, wdog, slp, pdis, tie, cyc, stb, we} = '0;
    {adr, wdat, sel, mismatches, check_count} = {12'h0, 32'h0, 4'hf, 64'h0};
    // Power-on with the pin held low: delays run out behind the pin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    chk("por_hold", cr, 1);
    pon <= 1'b0;
    repeat (80) @(posedge clk);
    chk("pin_hold", cr, 1);
    pin_n <= 1'b1;
    lowt();
    chk("pin_late", n <= 4, 1);
    rdc("por_flag", 12'h238, 32'h0);
    // Start-up delay for every mode class and timer setting
    foreach (rows[i]) begin
      mode <= rows[i].mode;
      pdis <= rows[i].pdis;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      lowt();
      chk("startup", n >= rows[i].dly - 4 && n <= rows[i].dly + 7, 1);
      rdc("status_rst", 12'h00c, 32'h18);
    end
    wb(1'b1, 12'h238, 32'h3);
    rdc("flags_set", 12'h238, 32'h3);
    wb(1'b1, 12'h00c, 32'h0);
    rdc("status_ro", 12'h00c, 32'h18);
    wb(1'b1, 12'h00c, 32'he7);
    rdc("status_wr", 12'h00c, 32'hff);
    rdc("unmapped", 12'h100, 32'h0);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    pin_n <= 1'b1;
    watch(8);
    chk("pin_glitch", hit, 0);
    // Pin reset while running: no start-up delay on release
    pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("pin_reset", cr, 1);
    pin_n <= 1'b1;
    lowt();
    chk("pin_release", n <= 4, 1);
    rdc("pin_run_status", 12'h00c, 32'h1f);
    rdc("flags_kept", 12'h238, 32'h3);
    // Watchdog while running, then while sleeping
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    watch(8);
    chk("wd_reset", {hit, cr, hl, hp}, 4'b1011);
    chk("pin_oe", oe, 0);
    rdc("wd_status", 12'h00c, 32'h0f);
    slp <= 1'b1;
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    watch(8);
    chk("wd_wake", {hit, hw}, 2'b01);
    rdc("wake_status", 12'h00c, 32'h07);
    // Crystal wake waits for the start-up count, still without a reset
    mode <= 3'h0;
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    watch(8);
    chk("xtal_wait", {hit, hw}, 2'b00);
    watch(40);
    chk("xtal_wake", {hit, hw}, 2'b01);
    mode <= 3'h5;
    pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    pin_n <= 1'b1;
    lowt();
    rdc("sleep_pin_status", 12'h00c, 32'h17);
    slp <= 1'b0;
    tie <= 1'b1;
    pin_n <= 1'b0;
    watch(10);
    chk("tied_pin", hit, 0);
    {tie, pin_n, pon} <= 3'b011;
    watch(10);
    chk("late_dip", hit, 0);
    {pon, bdet} <= 2'b01;
    repeat (2) @(posedge clk);
    bdet <= 1'b0;
    watch(8);
    chk("short_dip", hit, 0);
    {ben, bdet} <= 2'b01;
    watch(8);
    chk("dip_off", hit, 0);
    // Brown-out again inside the power-up delay restarts it from zero
    {ben, pdis} <= 2'b10;
    repeat (6) @(posedge clk);
    bdet <= 1'b0;
    repeat (10) @(posedge clk);
    bdet <= 1'b1;
    repeat (6) @(posedge clk);
    bdet <= 1'b0;
    lowt();
    chk("dip_restart", n >= 16 && n <= 27, 1);
    rdc("dip_flags", 12'h238, 32'h2);
    rdc("dip_status", 12'h00c, 32'h1f);
    tally_and_finish();
  end
endmodule : rsseq_top_bench
